/* dab_acq_bf.sv */
// Two acquisition channels with downconverters, DMA banks, meters and summation
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dab_defs.svh"
module dab_acq_bf #(
  parameter int AW = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [11:0] i_adc0,
  input wire logic [11:0] i_adc1,
  input wire logic [11:0] i_test,
  input wire logic [11:0] i_loop,
  input wire logic i_gate,
  input wire logic [31:0] i_chain_i,
  input wire logic [31:0] i_chain_q,
  input wire logic i_chain_valid,
  output logic [31:0] o_chain_i,
  output logic [31:0] o_chain_q,
  output logic o_chain_valid,
  input wire logic [1:0] i_dma_ready,
  output logic [1:0] o_dma_valid,
  output logic [31:0] o_dma0_data,
  output logic [31:0] o_dma1_data,
  output logic [2:0] o_thr_irq,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  localparam int T = `DAB_TAPS;

  typedef struct packed {
    logic [11:0] a0m, a0s, a1m, a1s;
    logic gm, gs, gd;
    logic [1:0][7:0] ctrl;
    logic [1:0][31:0] tune;
    logic [1:0][20:0] dec;
    logic [1:0][31:0] ph;
    logic [2:0][15:0] gain;
    logic [2:0][4:0] mcfg;
    logic [2:0][31:0] thr;
    logic [3:0] sctl;
    logic [1:0][15:0] len;
    logic [1:0][T-1:0][15:0] coef;
    logic [1:0][31:0] nco;
    logic [1:0][47:0] a1i, a1q, a2i, a2q, a3i, a3q;
    logic [1:0][7:0] n1, n2;
    logic [1:0] n3;
    logic [1:0][23:0] d3i, d3q;
    logic [1:0] d3v;
    logic [1:0][T-1:0][23:0] dli, dlq;
    logic [1:0][23:0] oi, oq;
    logic [1:0] ov;
    logic [23:0] si, sq;
    logic sv;
    logic [31:0] ci, cq, xi, xq;
    logic xv;
    logic [31:0] ts;
    dab_pkg::dab_dma_t [1:0] st;
    logic [1:0][AW:0] wp, rp;
    logic [1:0][15:0] cnt, mlen;
    logic [1:0][31:0] tsl, qw;
    logic [1:0][1:0] mc;
    logic [1:0] qp, ovf, dv;
    logic [1:0][31:0] dd;
    logic [31:0] rd;
  } dab_st_t;

  dab_st_t q;
  dab_st_t n;
  logic [31:0] mem [2][2**AW];
  logic [1:0] we;
  logic [1:0][AW-1:0] wa;
  logic [1:0][31:0] wdw;
  logic [2:0] clr;
  logic [2:0][31:0] pwr;
  logic [2:0] irq;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] adr(input logic [7:0] b, input int k);
    return b + 8'(4 * k);
  endfunction : adr

  function automatic logic [31:0] sx(input logic [23:0] v);
    return 32'($signed(v));
  endfunction : sx

  function automatic logic [31:0] gmul(input logic [31:0] x, input logic [15:0] g);
    logic signed [47:0] p;
    p = $signed(x) * $signed(g);
    return 32'(p >>> `DAB_G_FRAC);
  endfunction : gmul

  // Coarse quarter-turn oscillator: cos/sin in {1,0,-1}
  function automatic logic [25:0] mix(input logic [11:0] x, input logic [1:0] ph);
    logic signed [12:0] v;
    v = 13'($signed(x));
    case (ph)
      2'h0: return {v, 13'h0};
      2'h1: return {13'h0, -v};
      2'h2: return {-v, 13'h0};
      default: return {13'h0, v};
    endcase
  endfunction : mix

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [11:0] x;
    logic [25:0] m;
    logic signed [47:0] s1i, s1q, s2i, s2q, s3i, s3q, fi, fq, ri, rq;
    logic [23:0] yi, yq, vi, vq;
    logic [31:0] li, lq, w;
    logic gr, gf, sv, wr, full, close;
    x = '0; m = '0; s1i = '0; s1q = '0; s2i = '0; s2q = '0; s3i = '0; s3q = '0;
    fi = '0; fq = '0; ri = '0; rq = '0; yi = '0; yq = '0; vi = '0; vq = '0;
    li = '0; lq = '0; w = '0; sv = 1'b0; wr = 1'b0; full = 1'b0; close = 1'b0;
    n = q;
    we = '0;
    wa = '0;
    wdw = '0;
    clr = '0;
    n.a0m = i_adc0;
    n.a0s = q.a0m;
    n.a1m = i_adc1;
    n.a1s = q.a1m;
    n.gm = i_gate;
    n.gs = q.gm;
    n.gd = q.gs;
    gr = q.gs & ~q.gd;
    gf = ~q.gs & q.gd;
    n.ts = q.ts + 32'h1;
    n.d3v = '0;
    n.ov = '0;
    n.sv = 1'b0;
    n.xv = 1'b0;
    n.rd = '0;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    if (i_wr) begin
      for (int k = 0; k < 2; k++) begin
        if (i_addr == adr(`DAB_CTRL, k)) n.ctrl[k] = i_wdata[7:0];
        if (i_addr == adr(`DAB_TUNE, k)) n.tune[k] = i_wdata;
        if (i_addr == adr(`DAB_DEC, k)) n.dec[k] = i_wdata[20:0];
        if (i_addr == adr(`DAB_PHASE, k)) n.ph[k] = i_wdata;
        if (i_addr == adr(`DAB_LEN, k)) n.len[k] = i_wdata[15:0];
      end
      for (int k = 0; k < 3; k++) begin
        if (i_addr == adr(`DAB_GAIN, k)) n.gain[k] = i_wdata[15:0];
        if (i_addr == adr(`DAB_MCFG, k)) n.mcfg[k] = i_wdata[4:0];
        if (i_addr == adr(`DAB_THR, k)) n.thr[k] = i_wdata;
      end
      if (i_addr == `DAB_SCTL) n.sctl = i_wdata[3:0];
      if (i_addr == `DAB_IRQ) clr = i_wdata[2:0];
      if (i_addr == `DAB_COEF) n.coef[i_wdata[20]][i_wdata[17:16]] = i_wdata[15:0];
    end
    if (i_rd) begin
      for (int k = 0; k < 2; k++) begin
        if (i_addr == adr(`DAB_CTRL, k)) n.rd = 32'(q.ctrl[k]);
        if (i_addr == adr(`DAB_TUNE, k)) n.rd = q.tune[k];
        if (i_addr == adr(`DAB_DEC, k)) n.rd = 32'(q.dec[k]);
        if (i_addr == adr(`DAB_PHASE, k)) n.rd = q.ph[k];
        if (i_addr == adr(`DAB_LEN, k)) n.rd = 32'(q.len[k]);
        if (i_addr == adr(`DAB_MLEN, k)) n.rd = 32'(q.mlen[k]);
      end
      for (int k = 0; k < 3; k++) begin
        if (i_addr == adr(`DAB_GAIN, k)) n.rd = 32'(q.gain[k]);
        if (i_addr == adr(`DAB_MCFG, k)) n.rd = 32'(q.mcfg[k]);
        if (i_addr == adr(`DAB_THR, k)) n.rd = q.thr[k];
        if (i_addr == adr(`DAB_PWR, k)) n.rd = pwr[k];
      end
      if (i_addr == `DAB_SCTL) n.rd = 32'(q.sctl);
      if (i_addr == `DAB_IRQ) n.rd = 32'(irq);
      if (i_addr == `DAB_STAT) n.rd = {24'h0, q.st[1], q.st[0], q.qp, q.ovf};
    end

    // ----------------------------------------
    // Downconverters
    // ----------------------------------------
    for (int c = 0; c < 2; c++) begin
      case (dab_pkg::dab_src_t'(q.ctrl[c][1:0]))
        dab_pkg::SRC_ADC0: x = q.a0s;
        dab_pkg::SRC_ADC1: x = q.a1s;
        dab_pkg::SRC_TEST: x = i_test;
        default: x = i_loop;
      endcase
      n.nco[c] = q.nco[c] + q.tune[c];
      m = mix(x, q.nco[c][31:30]);
      s1i = $signed(q.a1i[c]) + $signed(m[25:13]);
      s1q = $signed(q.a1q[c]) + $signed(m[12:0]);
      if (q.n1[c] >= q.dec[c][7:0]) begin
        n.n1[c] = '0;
        n.a1i[c] = '0;
        n.a1q[c] = '0;
        s2i = $signed(q.a2i[c]) + s1i;
        s2q = $signed(q.a2q[c]) + s1q;
        if (q.n2[c] >= q.dec[c][15:8]) begin
          n.n2[c] = '0;
          n.a2i[c] = '0;
          n.a2q[c] = '0;
          s3i = $signed(q.a3i[c]) + s2i;
          s3q = $signed(q.a3q[c]) + s2q;
          n.n3[c] = ~q.n3[c];
          if (q.n3[c]) begin
            n.a3i[c] = '0;
            n.a3q[c] = '0;
            n.d3i[c] = 24'(s3i >>> q.dec[c][20:16]);
            n.d3q[c] = 24'(s3q >>> q.dec[c][20:16]);
            n.d3v[c] = 1'b1;
          end else begin
            n.a3i[c] = s3i;
            n.a3q[c] = s3q;
          end
        end else begin
          n.n2[c] = q.n2[c] + 8'h1;
          n.a2i[c] = s2i;
          n.a2q[c] = s2q;
        end
      end else begin
        n.n1[c] = q.n1[c] + 8'h1;
        n.a1i[c] = s1i;
        n.a1q[c] = s1q;
      end
      if (q.d3v[c]) begin
        n.dli[c] = {q.dli[c][T-2:0], q.d3i[c]};
        n.dlq[c] = {q.dlq[c][T-2:0], q.d3q[c]};
        fi = '0;
        fq = '0;
        for (int t = 0; t < T; t++) begin
          fi += $signed(n.dli[c][t]) * $signed(q.coef[c][t]);
          fq += $signed(n.dlq[c][t]) * $signed(q.coef[c][t]);
        end
        yi = 24'(fi >>> `DAB_PH_FRAC);
        yq = 24'(fq >>> `DAB_PH_FRAC);
        ri = $signed(yi) * $signed(q.ph[c][15:0]) - $signed(yq) * $signed(q.ph[c][31:16]);
        rq = $signed(yi) * $signed(q.ph[c][31:16]) + $signed(yq) * $signed(q.ph[c][15:0]);
        n.oi[c] = 24'(gmul(32'(ri >>> `DAB_PH_FRAC), q.gain[c]));
        n.oq[c] = 24'(gmul(32'(rq >>> `DAB_PH_FRAC), q.gain[c]));
        n.ov[c] = 1'b1;
      end
    end

    // ----------------------------------------
    // Summation and chain
    // ----------------------------------------
    if (i_chain_valid) begin
      n.ci = i_chain_i;
      n.cq = i_chain_q;
    end
    if (q.ov[0]) begin
      li = (q.sctl[0] ? sx(q.oi[0]) : '0) + (q.sctl[1] ? sx(q.oi[1]) : '0);
      lq = (q.sctl[0] ? sx(q.oq[0]) : '0) + (q.sctl[1] ? sx(q.oq[1]) : '0);
      n.si = 24'(gmul(li, q.gain[2]));
      n.sq = 24'(gmul(lq, q.gain[2]));
      n.sv = 1'b1;
      n.xi = (q.sctl[`DAB_S_CHAIN] ? q.ci : '0) + sx(n.si);
      n.xq = (q.sctl[`DAB_S_CHAIN] ? q.cq : '0) + sx(n.sq);
      n.xv = 1'b1;
    end

    // ----------------------------------------
    // DMA banks
    // ----------------------------------------
    for (int c = 0; c < 2; c++) begin
      sv = q.ov[c];
      vi = q.oi[c];
      vq = q.oq[c];
      if (c == 0 && q.sctl[`DAB_S_TOFIFO]) begin
        sv = q.sv;
        vi = q.si;
        vq = q.sq;
      end
      full = (q.wp[c][AW] != q.rp[c][AW]) && (q.wp[c][AW-1:0] == q.rp[c][AW-1:0]);
      wr = 1'b0;
      w = '0;
      close = q.ctrl[c][`DAB_C_GATE] ? gf : (q.cnt[c] >= q.len[c]);
      if (q.qp[c]) begin
        w = q.qw[c];
        wr = 1'b1;
        n.qp[c] = 1'b0;
      end else if (q.st[c] == dab_pkg::DMA_META) begin
        case (q.mc[c])
          2'h0: w = 32'(c + 1);
          2'h1: w = q.tsl[c];
          default: w = 32'(q.mlen[c]);
        endcase
        wr = 1'b1;
        n.mc[c] = q.mc[c] + 2'h1;
        if (q.mc[c] == 2'h2) n.st[c] = dab_pkg::DMA_IDLE;
      end
      case (q.st[c])
        dab_pkg::DMA_IDLE: begin
          if (q.ctrl[c][`DAB_C_EN] & (q.ctrl[c][`DAB_C_GATE] ? gr : 1'b1)) begin
            n.st[c] = dab_pkg::DMA_RUN;
            n.cnt[c] = '0;
            n.tsl[c] = q.ts;
          end
        end
        dab_pkg::DMA_RUN: begin
          if (close) begin
            n.mlen[c] = q.cnt[c];
            n.mc[c] = '0;
            n.st[c] = q.ctrl[c][`DAB_C_META] ? dab_pkg::DMA_META : dab_pkg::DMA_IDLE;
            if (!q.ctrl[c][`DAB_C_GATE]) n.ctrl[c][`DAB_C_EN] = 1'b0;
          end else if (sv && !q.qp[c]) begin
            n.cnt[c] = q.cnt[c] + 16'h1;
            wr = 1'b1;
            if (q.ctrl[c][`DAB_C_FMT16]) begin
              w = {vq[23:8], vi[23:8]};
            end else begin
              w = sx(vi);
              n.qw[c] = sx(vq);
              n.qp[c] = !full;
            end
          end
        end
        default: ;
      endcase
      if (wr && full) begin
        n.ovf[c] = 1'b1;
      end else if (wr) begin
        we[c] = 1'b1;
        wa[c] = q.wp[c][AW-1:0];
        wdw[c] = w;
        n.wp[c] = q.wp[c] + 1'b1;
      end
      // Capture mode holds the bank until the whole transient is stored
      if ((q.wp[c] != q.rp[c]) && !(q.ctrl[c][`DAB_C_CAP] && q.st[c] != dab_pkg::DMA_IDLE)
          && (!q.dv[c] || i_dma_ready[c])) begin
        n.dd[c] = mem[c][q.rp[c][AW-1:0]];
        n.dv[c] = 1'b1;
        n.rp[c] = q.rp[c] + 1'b1;
      end else if (i_dma_ready[c]) begin
        n.dv[c] = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // State registers and bank memory
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.gain <= {3{`DAB_GAIN_RST}};
      q.ph <= {2{`DAB_PH_RST}};
      q.coef <= {(2 * T){`DAB_COEF_RST}};
      q.mcfg <= {3{`DAB_MCFG_RST}};
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge i_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (we[c]) mem[c][wa[c]] <= wdw[c];
    end
  end

  // ----------------------------------------
  // Power meters: two channels and the sum
  // ----------------------------------------
  for (genvar k = 0; k < 3; k++) begin : g_pm
    dab_pmeter u_pm (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(k == 2 ? q.sv : q.ov[k % 2]),
      .i_i(k == 2 ? q.si : q.oi[k % 2]),
      .i_q(k == 2 ? q.sq : q.oq[k % 2]),
      .i_shift(q.mcfg[k][3:0]),
      .i_above(q.mcfg[k][4]),
      .i_thr(q.thr[k]),
      .i_clr(clr[k]),
      .o_power(pwr[k]),
      .o_irq(irq[k])
    );
  end

  assign o_thr_irq = irq;
  assign o_chain_i = q.xi;
  assign o_chain_q = q.xq;
  assign o_chain_valid = q.xv;
  assign o_dma_valid = q.dv;
  assign o_dma0_data = q.dd[0];
  assign o_dma1_data = q.dd[1];
  assign o_rdata = q.rd;
endmodule : dab_acq_bf
`default_nettype wire

/* dab_defs.svh */
// Register offsets, field positions, reset values and sizes of the acquisition beamformer
`ifndef DAB_DEFS_SVH
`define DAB_DEFS_SVH

// ----------------------------------------
// Register byte offsets (channel k at +4*k)
// ----------------------------------------
`define DAB_CTRL 8'h00
`define DAB_TUNE 8'h08
`define DAB_DEC 8'h10
`define DAB_PHASE 8'h18
`define DAB_GAIN 8'h20
`define DAB_MCFG 8'h2c
`define DAB_THR 8'h38
`define DAB_PWR 8'h44
`define DAB_SCTL 8'h50
`define DAB_IRQ 8'h54
`define DAB_LEN 8'h58
`define DAB_MLEN 8'h60
`define DAB_COEF 8'h68
`define DAB_STAT 8'h6c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DAB_C_CAP 2
`define DAB_C_GATE 3
`define DAB_C_META 4
`define DAB_C_FMT16 5
`define DAB_C_EN 6
`define DAB_S_CHAIN 2
`define DAB_S_TOFIFO 3

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define DAB_GAIN_RST 16'h1000
`define DAB_PH_RST 32'h0000_7fff
`define DAB_COEF_RST 16'h2000
`define DAB_MCFG_RST 5'h0d
`define DAB_MAX_SHIFT 4'hd
`define DAB_TAPS 4
`define DAB_PH_FRAC 15
`define DAB_G_FRAC 12

`endif

/* dab_pkg.sv */
// Types shared by the acquisition beamformer files
`default_nettype none
package dab_pkg;
  typedef enum logic [1:0] {SRC_ADC0, SRC_ADC1, SRC_TEST, SRC_LOOP} dab_src_t;
  typedef enum logic [1:0] {DMA_IDLE, DMA_RUN, DMA_META} dab_dma_t;
endpackage : dab_pkg
`default_nettype wire

/* dab_pmeter.sv */
// Averaging power meter with threshold detector
`timescale 1ns/1ps
`default_nettype none
`include "dab_defs.svh"
module dab_pmeter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [23:0] i_i,
  input wire logic [23:0] i_q,
  input wire logic [3:0] i_shift,
  input wire logic i_above,
  input wire logic [31:0] i_thr,
  input wire logic i_clr,
  output logic [31:0] o_power,
  output logic o_irq
);
  typedef struct packed {
    logic [47:0] acc;
    logic [13:0] cnt;
    logic [31:0] pwr;
    logic irq;
  } dab_pm_t;

  dab_pm_t q;
  dab_pm_t n;

  always_comb begin
    logic [3:0] sh;
    logic [47:0] p;
    logic [47:0] a;
    logic [13:0] lim;
    logic hit;
    sh = (i_shift > `DAB_MAX_SHIFT) ? `DAB_MAX_SHIFT : i_shift;
    p = 48'(($signed(i_i) * $signed(i_i) + $signed(i_q) * $signed(i_q)) >>> 16);
    a = q.acc + p;
    lim = 14'((32'h1 << sh) - 32'h1);
    hit = 1'b0;
    n = q;
    if (i_valid) begin
      if (q.cnt >= lim) begin
        n.pwr = 32'(a >> sh);
        n.acc = '0;
        n.cnt = '0;
        hit = i_above ? (n.pwr > i_thr) : (n.pwr < i_thr);
      end else begin
        n.acc = a;
        n.cnt = q.cnt + 14'h1;
      end
    end
    n.irq = hit | (q.irq & ~i_clr);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_power = q.pwr;
  assign o_irq = q.irq;
endmodule : dab_pmeter
`default_nettype wire

/* dab_acq_bf_assertions.sv */
// Port-level checks for the acquisition beamformer
`timescale 1ns/1ps
`default_nettype none
`include "dab_defs.svh"
module dab_acq_bf_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [1:0] i_dma_ready,
  input wire logic [1:0] o_dma_valid,
  input wire logic [31:0] o_dma0_data,
  input wire logic [31:0] o_dma1_data,
  input wire logic [31:0] o_chain_i,
  input wire logic [31:0] o_chain_q,
  input wire logic o_chain_valid,
  input wire logic [2:0] o_thr_irq,
  input wire logic [31:0] o_rdata
);
  // Flags that no clear write touches this cycle
  logic [2:0] keep;
  assign keep = o_thr_irq & ~((i_wr && i_addr == `DAB_IRQ) ? i_wdata[2:0] : 3'h0);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED: assert property (i_rd && i_addr == 8'hf0 |=> o_rdata == 32'h0)
    else $error("unmapped read returned data");
  AST_DMA0_HOLD: assert property (o_dma_valid[0] && !i_dma_ready[0] |=>
    o_dma_valid[0] && $stable(o_dma0_data)) else $error("bank 1 word dropped while stalled");
  AST_DMA1_HOLD: assert property (o_dma_valid[1] && !i_dma_ready[1] |=>
    o_dma_valid[1] && $stable(o_dma1_data)) else $error("bank 2 word dropped while stalled");
  AST_CHAIN_PULSE: assert property (o_chain_valid |=> !o_chain_valid)
    else $error("chain valid longer than one cycle");
  AST_CHAIN_I_HOLD: assert property (!o_chain_valid |-> $stable(o_chain_i))
    else $error("chain I changed without valid");
  AST_CHAIN_Q_HOLD: assert property (!o_chain_valid |-> $stable(o_chain_q))
    else $error("chain Q changed without valid");
  AST_IRQ_STICKY: assert property (|keep |=> (o_thr_irq & $past(keep)) == $past(keep))
    else $error("threshold flag dropped without a clear");
endmodule : dab_acq_bf_chk
bind dab_acq_bf dab_acq_bf_chk dab_acq_bf_chk_inst (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
  .i_rd, .i_dma_ready, .o_dma_valid, .o_dma0_data, .o_dma1_data, .o_chain_i, .o_chain_q,
  .o_chain_valid, .o_thr_irq, .o_rdata);
`default_nettype wire

/* dab_host_sink.sv */
// Host-side DMA sink: takes bank words, optionally stalling every other cycle
`timescale 1ns/1ps
`default_nettype none
module dab_host_sink (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic [1:0] i_valid,
  input wire logic [31:0] i_data0,
  input wire logic [31:0] i_data1,
  output logic [1:0] o_ready
);
  logic [31:0] q0[$];
  logic [31:0] q1[$];
  logic ph_q;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      if (i_valid[0] && o_ready[0]) q0.push_back(i_data0);
      if (i_valid[1] && o_ready[1]) q1.push_back(i_data1);
    end
  end
  assign o_ready = (i_slow && ph_q) ? 2'b00 : 2'b11;
endmodule : dab_host_sink
`default_nettype wire

/* dab_acq_bf_tb.sv */
// Self-checking bench for the acquisition beamformer
`timescale 1ns/1ps
`default_nettype none
`include "dab_defs.svh"
module dab_acq_bf_tb;
  logic i_clk, i_rst, i_gate, i_chain_valid, i_wr, i_rd, o_chain_valid, slow;
  logic [11:0] i_adc0, i_adc1, i_test, i_loop;
  logic [31:0] i_chain_i, i_chain_q, i_wdata, o_chain_i, o_chain_q, o_dma0_data, o_dma1_data;
  logic [31:0] o_rdata, v, m, n;
  logic [7:0] i_addr;
  logic [1:0] i_dma_ready, o_dma_valid;
  logic [2:0] o_thr_irq;
  int bad_count, samples_checked, cyc;
  logic [7:0] ra[5] = '{`DAB_PHASE, `DAB_GAIN, `DAB_GAIN + 8'h8, `DAB_MCFG, 8'hf0};
  logic [31:0] rv[5] = '{`DAB_PH_RST, 32'h1000, 32'h1000, 32'h0d, 32'h0};
  dab_acq_bf dab_acq_bf_inst (.i_clk, .i_rst, .i_adc0, .i_adc1, .i_test, .i_loop, .i_gate,
    .i_chain_i, .i_chain_q, .i_chain_valid, .o_chain_i, .o_chain_q, .o_chain_valid, .i_dma_ready,
    .o_dma_valid, .o_dma0_data, .o_dma1_data, .o_thr_irq, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata);
  dab_host_sink dab_host_sink_inst (.i_clk, .i_rst, .i_slow(slow), .i_valid(o_dma_valid),
    .i_data0(o_dma0_data), .i_data1(o_dma1_data), .o_ready(i_dma_ready));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {i_rst, i_gate, i_chain_valid, i_wr, i_rd, slow} = 6'b100000;
    {i_adc0, i_adc1, i_test, i_loop} = {12'h400, 12'hc00, 12'h300, 12'hd00};
    {i_chain_i, i_chain_q, i_addr, i_wdata} = '0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      rd(ra[k], v);
      chk(v, rv[k], "reset value");
    end
    wr(`DAB_TUNE + 8'h4, 32'hdead_beef);
    wr(`DAB_DEC, 32'h0001_ffff);
    rd(`DAB_TUNE + 8'h4, v);
    chk(v, 32'hdead_beef, "tuning word");
    rd(`DAB_DEC, v);
    chk(v, 32'h0001_ffff, "largest decimation");
    wr(`DAB_DEC, 32'h0);
    // Reset again so tuning word and oscillator phase start from zero
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`DAB_TUNE + 8'h4, v);
    chk(v, 32'h0, "tuning word after reset");
    $display("registers done");
    wr(`DAB_LEN + 8'h4, 32'h8);
    for (int s = 0; s < 4; s++) begin
      slow <= s[0];
      wr(`DAB_CTRL + 8'h4, 32'h40 | s);
      for (n = 0; n < 300 && dab_host_sink_inst.q1.size() < 16; n++) @(posedge i_clk);
      v = dab_host_sink_inst.q1[14];
      chk({31'h0, v[31]}, {31'h0, s[0]}, "I sign per source");
      chk({31'h0, v[31:23] == {9{v[23]}}}, 32'h1, "24-bit sign extension");
      rd(`DAB_MLEN + 8'h4, v);
      chk(v, 32'h8, "preset link length");
      rd(`DAB_CTRL + 8'h4, v);
      chk(v, 32'(s), "enable cleared at link end");
      chk(32'(dab_host_sink_inst.q1.size()), 32'h10, "preset word count");
      dab_host_sink_inst.q1.delete();
    end
    $display("sources done");
    slow <= 1'b1;
    wr(`DAB_CTRL, 32'h7a);
    repeat (5) @(posedge i_clk);
    i_gate <= 1'b1;
    repeat (40) @(posedge i_clk);
    i_gate <= 1'b0;
    for (n = 0; n < 200 && (n < 2 || v[5:4] != 2'b00 || o_dma_valid[0]); n++) rd(`DAB_STAT, v);
    n = 32'(dab_host_sink_inst.q0.size());
    v = dab_host_sink_inst.q0[n - 1];
    chk(n, v + 32'h3, "gate link words");
    chk(dab_host_sink_inst.q0[n - 3], 32'h1, "channel id");
    chk({31'h0, v >= 18 && v <= 22}, 32'h1, "gate sets length");
    rd(`DAB_MLEN, m);
    chk(m, v, "recorded length");
    $display("gate done");
    wr(`DAB_SCTL, 32'h4);
    i_chain_i <= 32'h0001_2345;
    i_chain_q <= 32'hffff_fff0;
    i_chain_valid <= 1'b1;
    @(posedge i_clk);
    i_chain_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    for (n = 0; n < 60 && o_chain_valid !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk(o_chain_i, 32'h0001_2345, "chain I pass");
    chk(o_chain_q, 32'hffff_fff0, "chain Q pass");
    $display("chain done");
    for (int k = 0; k < 2; k++) begin
      wr(`DAB_THR, k ? 32'hffff_ffff : 32'h0);
      wr(`DAB_MCFG, k ? 32'h0 : 32'h10);
      for (n = 0; n < 200 && o_thr_irq[0] !== 1'b1; n++) begin
        @(posedge i_clk);
        #1;
      end
      chk({31'h0, o_thr_irq[0]}, 32'h1, "threshold flag");
      rd(`DAB_PWR, v);
      chk({31'h0, v != 32'h0}, 32'h1, "power readable");
      wr(`DAB_THR, k ? 32'h0 : 32'hffff_ffff);
      repeat (4) @(posedge i_clk);
      chk({31'h0, o_thr_irq[0]}, 32'h1, "flag held");
      wr(`DAB_IRQ, 32'h1);
      #1;
      chk({31'h0, o_thr_irq[0]}, 32'h0, "flag cleared");
    end
    $display("threshold done");
    dab_host_sink_inst.q0.delete();
    wr(`DAB_SCTL, 32'h9);
    wr(`DAB_GAIN + 8'h8, 32'h800);
    wr(`DAB_MCFG + 8'h8, 32'h10);
    wr(`DAB_LEN, 32'h4);
    wr(`DAB_CTRL, 32'h42);
    for (n = 0; n < 300 && dab_host_sink_inst.q0.size() < 8; n++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
    #1;
    chk(dab_host_sink_inst.q0[6], 32'h2ff, "summed I at half gain");
    chk(dab_host_sink_inst.q0[7], 32'h0, "summed Q in bank 1");
    chk(32'(dab_host_sink_inst.q0.size()), 32'h8, "summed word count");
    chk({31'h0, o_thr_irq[2]}, 32'h1, "sum threshold flag");
    $display("sum done");
    tally_and_finish();
  end
endmodule : dab_acq_bf_tb
`default_nettype wire
